// [rtl/cfil_cfg.svh]
// Constants for the charger fault interrupt logic.
`ifndef CFIL_CFG_SVH
`define CFIL_CFG_SVH
`define CFIL_ADDR_FLAG 12'h000
`define CFIL_ADDR_MASK 12'h004
`define CFIL_ADDR_STAT 12'h008
`define CFIL_ADDR_CTRL 12'h00c
`define CFIL_NSRC 8
`define CFIL_SRC_DONE 0
`define CFIL_SRC_ILIM 1
`define CFIL_SRC_DPPM 2
`define CFIL_SRC_VLOOP 3
`define CFIL_SRC_THERM 4
`define CFIL_SRC_PGOOD 5
`define CFIL_SRC_BOCP 6
`define CFIL_SRC_CV 7
`define CFIL_CTRL_START_OK 0
`define CFIL_CTRL_START_FAULT 1
`define CFIL_CTRL_DOUBLE 2
`define CFIL_CTRL_CHG_EN 3
`define CFIL_MASK_RESET 8'h00
`define CFIL_CLK_MHZ 100
`define CFIL_PULSE_US 128
`define CFIL_PULSE_CYC (`CFIL_PULSE_US * `CFIL_CLK_MHZ)
`endif

// [rtl/cfil_pkg.sv]
// Types shared by the charger fault interrupt logic.
package cfil_pkg;
  typedef logic [7:0] cfil_src_t;
  typedef enum logic [1:0] {CFIL_WAIT, CFIL_RUN, CFIL_DEAD} cfil_start_e;
  typedef struct packed {
    logic done;
    logic rch;
    logic ilim;
    logic dppm;
    logic vloop;
    logic therm;
    logic pgood;
    logic bocp;
    logic cv;
  } cfil_stat_s;
  typedef struct packed {
    logic chg_enable;
    logic chg_paused;
    logic reduced_current;
    logic timer_reset;
    logic timer_double;
    logic battery_disconnect;
  } cfil_resp_s;
endpackage

// [rtl/cfil_pulse.sv]
// Fixed-width interrupt pulse generator.
`timescale 1ns/1ps
`include "cfil_cfg.svh"
module cfil_pulse
  import cfil_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  output logic busy,
  output logic pulse_start
);
  typedef struct packed {
    logic [13:0] cnt;
    logic pend;
  } cfil_pst_s;
  localparam logic [13:0] LEN = 14'(`CFIL_PULSE_CYC);
  cfil_pst_s st_r;
  cfil_pst_s st_nxt;
  logic start;

  always_comb begin
    st_nxt = st_r;
    start = 1'b0;
    if (req) begin
      st_nxt.pend = 1'b1;
    end
    if (st_r.cnt != 14'h0) begin
      st_nxt.cnt = st_r.cnt - 14'h1;
    end else if (st_r.pend || req) begin
      st_nxt.cnt = LEN;
      st_nxt.pend = 1'b0;
      start = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.cnt != 14'h0;
  assign pulse_start = start;

  a_pulse_width: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> busy [*8] ##1 (busy [*1]))
    else $error("pulse ended early");
endmodule

// [rtl/cfil_top.sv]
// Charger fault flags, masking, interrupt pulses and charger responses.
`timescale 1ns/1ps
`include "cfil_cfg.svh"
module cfil_top
  import cfil_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cfil_stat_s stat,
  output logic int_n_o,
  output logic int_n_oe,
  output logic irq,
  output cfil_resp_s resp
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cfil_start_e start;
    cfil_src_t flag;
    cfil_src_t mask;
    cfil_src_t live;
    logic [3:0] ctrl;
    cfil_stat_s prev;
    logic paused;
    logic [31:0] rdata;
    logic [8:0] stat_seen;
  } cfil_st_s;

  cfil_st_s st_r;
  cfil_st_s st_nxt;
  logic busy;
  logic pulse_start;
  logic fire;
  // Cycles that a granted event has waited for its pulse to start.
  // A counter is used because the worst wait is a whole pulse long.
  logic [14:0] wait_r;

  function automatic cfil_src_t live_vec(input cfil_stat_s s);
    cfil_src_t v;
    v = '0;
    v[`CFIL_SRC_DONE] = s.done;
    v[`CFIL_SRC_ILIM] = s.ilim;
    v[`CFIL_SRC_DPPM] = s.dppm;
    v[`CFIL_SRC_VLOOP] = s.vloop;
    v[`CFIL_SRC_THERM] = s.therm;
    v[`CFIL_SRC_PGOOD] = s.pgood;
    v[`CFIL_SRC_BOCP] = s.bocp;
    v[`CFIL_SRC_CV] = s.cv;
    return v;
  endfunction

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  cfil_src_t cur;
  cfil_src_t old;
  cfil_src_t edge_ev;
  cfil_src_t newset;

  always_comb begin
    cur = live_vec(stat);
    old = live_vec(st_r.prev);
    edge_ev = cur & ~old;
    edge_ev[`CFIL_SRC_PGOOD] = cur[`CFIL_SRC_PGOOD] ^ old[`CFIL_SRC_PGOOD];
    newset = edge_ev & ~st_r.flag;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    fire = 1'b0;
    st_nxt.prev = stat;
    st_nxt.live = cur;
    unique case (st_r.start)
      CFIL_WAIT: begin
        if (st_r.ctrl[`CFIL_CTRL_START_FAULT]) begin
          st_nxt.start = CFIL_DEAD;
        end else if (st_r.ctrl[`CFIL_CTRL_START_OK]) begin
          st_nxt.start = CFIL_RUN;
        end
      end
      CFIL_RUN: begin
      end
      CFIL_DEAD: begin
      end
    endcase
    if (wr) begin
      unique case (paddr)
        `CFIL_ADDR_MASK: st_nxt.mask = pwdata[7:0];
        `CFIL_ADDR_CTRL: st_nxt.ctrl = pwdata[3:0];
        default: begin
        end
      endcase
    end
    if (rd && paddr == `CFIL_ADDR_FLAG) begin
      st_nxt.flag = '0;
    end
    // Set wins over a clearing read in the same cycle.
    st_nxt.flag = st_nxt.flag | edge_ev;
    // masked sources silent; only fresh edges fire
    if (st_r.start == CFIL_RUN && |(newset & ~st_r.mask)) begin
      fire = 1'b1;
    end
    // pause on termination, resume on toggle or recharge
    if (edge_ev[`CFIL_SRC_DONE]) begin
      st_nxt.paused = 1'b1;
    end else if (stat.rch || edge_ev[`CFIL_SRC_PGOOD]
                 || (wr && paddr == `CFIL_ADDR_CTRL
                     && pwdata[`CFIL_CTRL_CHG_EN] != st_r.ctrl[`CFIL_CTRL_CHG_EN])) begin
      st_nxt.paused = 1'b0;
    end
    st_nxt.stat_seen = stat;
    // Read data is latched in the setup cycle and stands until the next read setup.
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CFIL_ADDR_FLAG: st_nxt.rdata = {24'h0, st_nxt.flag};
        `CFIL_ADDR_MASK: st_nxt.rdata = {24'h0, st_r.mask};
        `CFIL_ADDR_STAT: st_nxt.rdata = {24'h0, cur};
        `CFIL_ADDR_CTRL: st_nxt.rdata = {26'h0, st_r.start, st_r.ctrl[3:0]} >> 0;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{start: CFIL_WAIT, mask: `CFIL_MASK_RESET, ctrl: 4'h8, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 15'h0;
    end else if (pulse_start) begin
      wait_r <= 15'h0;
    end else if (fire || wait_r != 15'h0) begin
      wait_r <= wait_r + 15'h1;
    end
  end

  cfil_pulse u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .req(fire),
    .busy(busy),
    .pulse_start(pulse_start)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // open drain low only while pulsing
  assign int_n_o = 1'b0;
  assign int_n_oe = busy;
  assign irq = |(st_r.flag & ~st_r.mask);
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    resp = '0;
    // supply low disables charging and resets timer
    resp.chg_enable = st_r.ctrl[`CFIL_CTRL_CHG_EN] && stat.pgood && !stat.bocp && !st_r.paused;
    resp.chg_paused = st_r.paused;
    resp.battery_disconnect = stat.bocp;
    resp.timer_reset = !stat.pgood || edge_ev[`CFIL_SRC_DONE];
    resp.reduced_current = stat.ilim | stat.dppm | stat.vloop | stat.therm;
    resp.timer_double = resp.reduced_current && st_r.ctrl[`CFIL_CTRL_DOUBLE];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_int_early: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.start != CFIL_RUN |-> !fire)
    else $error("interrupt before valid start-up");
  a_masked_silent: assert property (@(posedge pclk) disable iff (!presetn)
    fire |-> |(edge_ev & ~st_r.flag & ~st_r.mask))
    else $error("pulse from masked source");
  a_event_pulses: assert property (@(posedge pclk) disable iff (!presetn)
    wait_r <= 15'd12801)
    else $error("event produced no pulse");
  a_unmask_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_ev == '0) |-> !fire)
    else $error("pulse without fresh edge");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (|st_r.flag && !(rd && paddr == `CFIL_ADDR_FLAG)) |=> (st_r.flag & $past(st_r.flag)) == $past(st_r.flag))
    else $error("flag lost without read");
  a_done_pause: assert property (@(posedge pclk) disable iff (!presetn)
    edge_ev[`CFIL_SRC_DONE] |=> st_r.paused)
    else $error("termination did not pause");
  a_ocp_off: assert property (@(posedge pclk) disable iff (!presetn)
    stat.bocp |-> !resp.chg_enable && resp.battery_disconnect)
    else $error("overcurrent did not disconnect");
  a_double_gate: assert property (@(posedge pclk) disable iff (!presetn)
    resp.timer_double |-> st_r.ctrl[`CFIL_CTRL_DOUBLE])
    else $error("timer doubled without option");
  a_pgood_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(stat.pgood) |=> st_r.flag[`CFIL_SRC_PGOOD])
    else $error("supply-good fall not flagged");
endmodule

// [bench/cfil_host.sv]
// Host-side model: pull-up on the open-drain interrupt line and a pulse counter.
`timescale 1ns/1ps
module cfil_host (
  input wire logic pclk,
  input wire logic int_n_o,
  input wire logic int_n_oe,
  output logic int_n,
  output int pulses,
  output int width
);
  int run_len;
  assign int_n = int_n_oe ? int_n_o : 1'b1;
  initial begin
    pulses = 0;
    width = 0;
    run_len = 0;
  end
  always @(posedge pclk) begin
    if (int_n === 1'b0) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      pulses <= pulses + 1;
      width <= run_len;
      run_len <= 0;
    end
  end
endmodule

// [bench/charger_fault_interrupt_logic_tb.sv]
// Self-checking testbench for the charger fault interrupt logic.
`timescale 1ns/1ps
`include "cfil_cfg.svh"
module charger_fault_interrupt_logic_tb;
  import cfil_pkg::*;
  typedef struct packed {logic [8:0] st; logic [7:0] fl; logic [5:0] rm, rv;} cfil_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_n_o, int_n_oe, irq, int_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  cfil_stat_s stat;
  cfil_resp_s resp;
  int pulses, width, n_errors, checked;
  // Supply good is held high as the baseline so that charging is allowed.
  localparam logic [8:0] BASE = 9'h004;
  cfil_row_s rows [8] = '{
    '{9'h104, 8'h01, 6'h10, 6'h10}, '{9'h044, 8'h02, 6'h0a, 6'h0a},
    '{9'h024, 8'h04, 6'h0a, 6'h0a}, '{9'h014, 8'h08, 6'h0a, 6'h0a},
    '{9'h00c, 8'h10, 6'h0a, 6'h0a}, '{9'h000, 8'h20, 6'h20, 6'h00},
    '{9'h006, 8'h40, 6'h21, 6'h01}, '{9'h005, 8'h80, 6'h00, 6'h00}};
  cfil_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stat(stat), .int_n_o(int_n_o), .int_n_oe(int_n_oe), .irq(irq),
    .resp(resp));
  cfil_host u_host (.pclk(pclk), .int_n_o(int_n_o), .int_n_oe(int_n_oe), .int_n(int_n),
    .pulses(pulses), .width(width));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wait_for(int n);
    int k;
    k = 0;
    while (pulses < n && k < 40000) begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; stat = BASE; n_errors = 0; checked = 0;
    idle(10);
    presetn <= 1'b1;
    idle(1);
    chk("int_oe", int_n_oe, 32'h0);
    apb(1'b0, `CFIL_ADDR_MASK, 32'h0);
    chk("mask", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", rd, 32'h0);
    stat <= 9'h104;
    idle(20);
    chk("pre_start", pulses, 32'h0);
    apb(1'b1, `CFIL_ADDR_MASK, 32'hff);
    apb(1'b1, `CFIL_ADDR_CTRL, 32'hd);
    stat <= BASE;
    idle(3);
    apb(1'b0, `CFIL_ADDR_FLAG, 32'h0);
    foreach (rows[i]) begin
      stat <= rows[i].st;
      idle(3);
      apb(1'b0, `CFIL_ADDR_FLAG, 32'h0);
      chk("flag", rd[7:0], rows[i].fl);
      chk("resp", resp & rows[i].rm, rows[i].rv);
      chk("masked", {irq, pulses[7:0]}, 32'h0);
      stat <= BASE;
      idle(3);
      apb(1'b0, `CFIL_ADDR_FLAG, 32'h0);
    end
    apb(1'b1, `CFIL_ADDR_MASK, 32'h0);
    stat <= 9'h064;
    wait_for(1);
    chk("merged", pulses, 32'h1);
    chk("width", width, `CFIL_PULSE_CYC);
    chk("irq_set", irq, 32'h1);
    apb(1'b0, `CFIL_ADDR_FLAG, 32'h0);
    chk("flag2", rd[7:0], 8'h06);
    idle(2);
    chk("irq_clr", irq, 32'h0);
    stat <= 9'h074;
    idle(3);
    stat <= 9'h064;
    idle(3);
    stat <= 9'h074;
    idle(13000);
    chk("no_rearm", pulses, 32'h2);
    apb(1'b0, `CFIL_ADDR_FLAG, 32'h0);
    stat <= 9'h064;
    idle(3);
    stat <= 9'h074;
    wait_for(3);
    chk("rearm", pulses, 32'h3);
    apb(1'b1, `CFIL_ADDR_MASK, 32'h10);
    stat <= 9'h07c;
    idle(3);
    apb(1'b0, `CFIL_ADDR_FLAG, 32'h0);
    apb(1'b1, `CFIL_ADDR_MASK, 32'h0);
    idle(50);
    chk("unmask", {int_n, pulses[7:0]}, 32'h103);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    apb(1'b1, `CFIL_ADDR_CTRL, 32'hb);
    stat <= 9'h104;
    idle(20);
    chk("start_fault", pulses, 32'h3);
    test_done();
  end
  initial begin
    #900000;
    n_errors++;
    test_done();
  end
endmodule
